// file: shared/awc_pkg.sv
// Package of opcode constants and operand-form types for the add-with-carry decoder.
package awc_pkg;
    // ==========================================================
    // Opcode bytes
    // ==========================================================
    localparam logic [7:0] AWC_OP_REG_FORMS = 8'h79;
    localparam logic [7:0] AWC_OP_RR_SHORT = 8'h89;
    localparam logic [7:0] AWC_OP_PREFIX = 8'h3C;
    localparam logic [7:0] AWC_OP_RR_LONG = 8'h89;
    // ==========================================================
    // Second-byte low-nibble operand-form codes
    // ==========================================================
    localparam logic [3:0] AWC_SUB_R_SA2 = 4'h0;
    localparam logic [3:0] AWC_SUB_R_SA1 = 4'h1;
    localparam logic [3:0] AWC_SUB_R_SFR = 4'h2;
    localparam logic [3:0] AWC_SUB_R_IMM = 4'h3;
    localparam logic [3:0] AWC_SUB_SA2_R = 4'h4;
    localparam logic [3:0] AWC_SUB_SA1_R = 4'h5;
    localparam logic [3:0] AWC_SUB_SFR_R = 4'h6;
    // ==========================================================
    // Byte positions and reset values
    // ==========================================================
    localparam logic [2:0] AWC_POS_FIRST = 3'h1;
    localparam logic [2:0] AWC_POS_LAST = 3'h7;
    localparam logic [7:0] AWC_RST_BYTE = 8'h00;
    localparam logic [3:0] AWC_RST_REG = 4'h0;

    // Operand forms handed to execute.
    typedef enum logic [3:0] {
        AWC_FORM_NONE = 4'b0000,
        AWC_FORM_R_IMM = 4'b0001,
        AWC_FORM_R_R = 4'b0010,
        AWC_FORM_R_SA2 = 4'b0011,
        AWC_FORM_R_SA1 = 4'b0100,
        AWC_FORM_SA2_R = 4'b0101,
        AWC_FORM_SA1_R = 4'b0110,
        AWC_FORM_R_SFR = 4'b0111,
        AWC_FORM_SFR_R = 4'b1000
    } awc_form_t;

    // Decoder sequencing states.
    typedef enum logic [2:0] {
        AWC_ST_IDLE = 3'b000,
        AWC_ST_REGB2 = 3'b001,
        AWC_ST_RRB2 = 3'b010,
        AWC_ST_PREB2 = 3'b011,
        AWC_ST_PRERR = 3'b100,
        AWC_ST_OPND = 3'b101,
        AWC_ST_SKIP = 3'b110
    } awc_state_t;
endpackage

// file: logic/awc_decode.sv
// Add-with-carry operand-form decoder fed by the fetch byte stream.
`timescale 1ns/1ps
module awc_decode
    import awc_pkg::*;
(
    input wire logic clk_sys, // Core clock, 40 MHz.
    input wire logic arst_n, // Asynchronous active-low reset.
    input wire logic fetch_valid, // Fetch byte is offered.
    input wire logic [7:0] fetch_byte, // Fetch byte value.
    input wire logic fetch_first, // Offered byte starts an instruction.
    output logic fetch_ready, // Decoder takes the byte.
    output logic dec_valid, // One-cycle pulse: decode result.
    output awc_form_t dec_form, // Decoded operand form.
    output logic [3:0] dest_register_field, // Destination register select.
    output logic [2:0] source_register_field, // Source register select.
    output logic [7:0] dec_operand, // Immediate or area offset.
    output logic [2:0] dec_length, // Instruction length in bytes.
    output logic add_with_carry_op, // Execute adds operands plus carry.
    output logic dec_undefined, // One-cycle pulse: undefined form.
    output logic dec_other // One-cycle pulse: first byte, or prefixed second byte, not handled here.
);
    awc_state_t state;
    awc_form_t pend_form;
    logic [3:0] pend_reg;
    logic [2:0] pos;
    logic take;

    // The decoder never stalls; every offered byte is consumed.
    assign fetch_ready = 1'b1;
    assign take = fetch_valid;

    // ==========================================================
    // Byte position counter
    // ==========================================================
    // Saturates at seven so an endless stream cannot wrap into a false byte one.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pos <= AWC_POS_FIRST;
        end else if (take && fetch_first) begin
            pos <= 3'h2;
        end else if (take && pos != AWC_POS_LAST) begin
            pos <= pos + 3'h1;
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    // A first-byte marker always restarts decode, so a stray stream resynchronises.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= AWC_ST_IDLE;
            pend_form <= AWC_FORM_NONE;
            pend_reg <= AWC_RST_REG;
        end else if (take) begin
            if (fetch_first) begin
                case (fetch_byte)
                    AWC_OP_REG_FORMS: state <= AWC_ST_REGB2;
                    AWC_OP_RR_SHORT: state <= AWC_ST_RRB2;
                    AWC_OP_PREFIX: state <= AWC_ST_PREB2;
                    default: state <= AWC_ST_SKIP;
                endcase
            end else begin
                case (state)
                    AWC_ST_REGB2: begin
                        pend_reg <= fetch_byte[7:4];
                        case (fetch_byte[3:0])
                            AWC_SUB_R_IMM: pend_form <= AWC_FORM_R_IMM;
                            AWC_SUB_R_SA2: pend_form <= AWC_FORM_R_SA2;
                            AWC_SUB_R_SA1: pend_form <= AWC_FORM_R_SA1;
                            AWC_SUB_SA2_R: pend_form <= AWC_FORM_SA2_R;
                            AWC_SUB_SA1_R: pend_form <= AWC_FORM_SA1_R;
                            AWC_SUB_R_SFR: pend_form <= AWC_FORM_R_SFR;
                            AWC_SUB_SFR_R: pend_form <= AWC_FORM_SFR_R;
                            default: pend_form <= AWC_FORM_NONE;
                        endcase
                        state <= (fetch_byte[3:0] <= AWC_SUB_SFR_R) ? AWC_ST_OPND : AWC_ST_SKIP;
                    end
                    AWC_ST_PREB2: state <= (fetch_byte == AWC_OP_RR_LONG) ? AWC_ST_PRERR : AWC_ST_SKIP;
                    AWC_ST_RRB2: state <= AWC_ST_SKIP;
                    AWC_ST_PRERR: state <= AWC_ST_SKIP;
                    AWC_ST_OPND: state <= AWC_ST_SKIP;
                    AWC_ST_SKIP: state <= AWC_ST_SKIP;
                    default: state <= AWC_ST_SKIP;
                endcase
            end
        end
    end

    // ==========================================================
    // Result outputs
    // ==========================================================
    // Results are registered; fields hold until the next result overwrites them.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dec_valid <= 1'b0;
            dec_form <= AWC_FORM_NONE;
            dest_register_field <= AWC_RST_REG;
            source_register_field <= 3'h0;
            dec_operand <= AWC_RST_BYTE;
            dec_length <= 3'h0;
            add_with_carry_op <= 1'b0;
            dec_undefined <= 1'b0;
            dec_other <= 1'b0;
        end else begin
            dec_valid <= 1'b0;
            dec_undefined <= 1'b0;
            dec_other <= 1'b0;
            add_with_carry_op <= 1'b0;
            if (take && fetch_first) begin
                dec_other <= !(fetch_byte == AWC_OP_REG_FORMS || fetch_byte == AWC_OP_RR_SHORT ||
                    fetch_byte == AWC_OP_PREFIX);
            end else if (take) begin
                case (state)
                    AWC_ST_REGB2: begin
                        if (fetch_byte[3:0] > AWC_SUB_SFR_R) begin
                            dec_undefined <= 1'b1;
                        end
                    end
                    AWC_ST_PREB2: begin
                        if (fetch_byte != AWC_OP_RR_LONG) begin
                            dec_other <= 1'b1;
                        end
                    end
                    AWC_ST_RRB2, AWC_ST_PRERR: begin
                        dec_valid <= 1'b1;
                        add_with_carry_op <= 1'b1;
                        dec_form <= AWC_FORM_R_R;
                        dest_register_field <= fetch_byte[7:4];
                        source_register_field <= fetch_byte[2:0];
                        dec_undefined <= fetch_byte[3];
                        dec_length <= (state == AWC_ST_RRB2) ? 3'h2 : 3'h3;
                    end
                    AWC_ST_OPND: begin
                        dec_valid <= 1'b1;
                        add_with_carry_op <= 1'b1;
                        dec_form <= pend_form;
                        dest_register_field <= pend_reg;
                        source_register_field <= 3'h0;
                        dec_operand <= fetch_byte;
                        dec_length <= 3'h3;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    // Multi-byte properties follow a gap-free byte stream only; stalled streams are left to the bench scoreboard.
    AST_R2_IMM: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h79) ##1 (take && !fetch_first && fetch_byte[3:0] == 4'h3)
        ##1 (take && !fetch_first) |=> (dec_valid && dec_form == AWC_FORM_R_IMM && dec_operand == $past(fetch_byte)))
        else $error("register-immediate form not decoded");
    AST_R3_SHORT: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h89) ##1 (take && !fetch_first)
        |=> (dec_valid && dec_form == AWC_FORM_R_R && source_register_field == $past(fetch_byte[2:0])))
        else $error("short register pair not decoded");
    AST_R3_LONG: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h3C) ##1 (take && !fetch_first && fetch_byte == 8'h89)
        ##1 (take && !fetch_first) |=> (dec_valid && dec_length == 3'h3 && dec_form == AWC_FORM_R_R))
        else $error("prefixed register pair not decoded");
    AST_R4_SA2: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h79) ##1 (take && !fetch_first && fetch_byte[3:0] == 4'h0)
        ##1 (take && !fetch_first) |=> (dec_form == AWC_FORM_R_SA2 && dec_valid))
        else $error("register from area two not decoded");
    AST_R9_SFR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h79) ##1 (take && !fetch_first && fetch_byte[3:0] == 4'h6)
        ##1 (take && !fetch_first) |=> (dec_form == AWC_FORM_SFR_R && dec_valid))
        else $error("special register destination not decoded");
    AST_R10_UNDEF: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h79) ##1 (take && !fetch_first && fetch_byte[3:0] > 4'h6)
        |=> (dec_undefined && !dec_valid) ##1 !dec_valid)
        else $error("undefined form not flagged");
    AST_R11_CARRY: assert property (@(posedge clk_sys) disable iff (!arst_n)
        dec_valid |-> add_with_carry_op)
        else $error("decoded form without add-with-carry");
    // The reported length must be the position of the byte that completed the decode.
    AST_R1_POS: assert property (@(posedge clk_sys) disable iff (!arst_n)
        dec_valid |-> (dec_length == $past(pos)))
        else $error("length differs from byte position");
    AST_R5_SA1: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h79) ##1 (take && !fetch_first && fetch_byte[3:0] == 4'h1)
        ##1 (take && !fetch_first)
        |=> (dec_valid && dec_form == AWC_FORM_R_SA1 && dec_operand == $past(fetch_byte)))
        else $error("register from area one not decoded");
    AST_R6_SA2R: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h79) ##1 (take && !fetch_first && fetch_byte[3:0] == 4'h4)
        ##1 (take && !fetch_first)
        |=> (dec_valid && dec_form == AWC_FORM_SA2_R && dec_operand == $past(fetch_byte)))
        else $error("area two destination not decoded");
    AST_R7_SA1R: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h79) ##1 (take && !fetch_first && fetch_byte[3:0] == 4'h5)
        ##1 (take && !fetch_first)
        |=> (dec_valid && dec_form == AWC_FORM_SA1_R && dec_operand == $past(fetch_byte)))
        else $error("area one destination not decoded");
    AST_R8_RSFR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte == 8'h79) ##1 (take && !fetch_first && fetch_byte[3:0] == 4'h2)
        ##1 (take && !fetch_first)
        |=> (dec_valid && dec_form == AWC_FORM_R_SFR && dec_operand == $past(fetch_byte)))
        else $error("special register source not decoded");
    AST_R1_FOREIGN: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (take && fetch_first && fetch_byte != 8'h79 && fetch_byte != 8'h89 && fetch_byte != 8'h3C)
        |=> (dec_other && !dec_valid && !dec_undefined))
        else $error("foreign first byte not passed on");
    // Coverage of the main scenarios.
    COV_IMM: cover property (@(posedge clk_sys) disable iff (!arst_n) dec_valid && dec_form == AWC_FORM_R_IMM);
    COV_RR: cover property (@(posedge clk_sys) disable iff (!arst_n) dec_valid && dec_form == AWC_FORM_R_R);
    COV_UNDEF: cover property (@(posedge clk_sys) disable iff (!arst_n) dec_undefined);
    COV_SFR: cover property (@(posedge clk_sys) disable iff (!arst_n) dec_valid && dec_form == AWC_FORM_SFR_R);
    COV_OTHER: cover property (@(posedge clk_sys) disable iff (!arst_n) dec_other);
endmodule

// file: tb/awc_fetch_model.sv
// Fetch-stage model that offers instruction bytes to the decoder.
`timescale 1ns/1ps
module awc_fetch_model (
    input wire logic clk_sys, // Core clock.
    input wire logic arst_n, // Asynchronous active-low reset.
    input wire logic fetch_ready, // Decoder takes the byte.
    output logic fetch_valid, // Byte offered.
    output logic [7:0] fetch_byte, // Byte value.
    output logic fetch_first // Byte starts an instruction.
);
    logic [8:0] pend[$];
    int unsigned stall_pct = 0;
    // Queue one byte; the flag marks the first byte of an instruction.
    task automatic push(input logic first, input logic [7:0] b);
        pend.push_back({first, b});
    endtask
    // ==========================================================
    // Byte offer
    // ==========================================================
    // An offer is held until taken; an idle bus inverts the byte on every idle cycle so stale data never looks valid.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pend.delete();
            fetch_valid <= 1'b0;
            fetch_first <= 1'b0;
            fetch_byte <= 8'h00;
        end else if (!fetch_valid || fetch_ready) begin
            if (pend.size() > 0 && ($urandom % 100) >= stall_pct) begin
                {fetch_first, fetch_byte} <= pend.pop_front();
                fetch_valid <= 1'b1;
            end else begin
                fetch_valid <= 1'b0;
                fetch_first <= 1'b0;
                fetch_byte <= ~fetch_byte;
            end
        end
    end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the add-with-carry decoder.
`timescale 1ns/1ps
module testbench;
    import awc_pkg::*;
    logic clk_sys, arst_n, fetch_valid, fetch_first, fetch_ready, dec_valid, add_with_carry_op, dec_undefined, dec_other;
    logic [7:0] fetch_byte, dec_operand, r8, v8;
    awc_form_t dec_form;
    logic [3:0] dest_register_field;
    logic [2:0] source_register_field, dec_length;
    logic [49:0] notes[$];
    int failures = 0;
    int checks = 0;
    awc_form_t form_of[7] = '{AWC_FORM_R_SA2, AWC_FORM_R_SA1, AWC_FORM_R_SFR, AWC_FORM_R_IMM, AWC_FORM_SA2_R,
        AWC_FORM_SA1_R, AWC_FORM_SFR_R};
    awc_decode awc_decode_i (.clk_sys(clk_sys), .arst_n(arst_n), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
        .fetch_first(fetch_first), .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_form(dec_form),
        .dest_register_field(dest_register_field), .source_register_field(source_register_field),
        .dec_operand(dec_operand), .dec_length(dec_length), .add_with_carry_op(add_with_carry_op),
        .dec_undefined(dec_undefined), .dec_other(dec_other));
    awc_fetch_model awc_fetch_model_i (.clk_sys(clk_sys), .arst_n(arst_n), .fetch_ready(fetch_ready),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_first(fetch_first));
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic compare(input logic [24:0] seen, input logic [24:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    // Note a result: flags are valid, undefined, other; the mask hides fields the result leaves open.
    task automatic note(input logic [2:0] f, input logic [3:0] fm, d, input logic [2:0] s, input logic [7:0] o,
        input logic [2:0] len, input logic [24:0] mask);
        notes.push_back({mask, f, fm, d, s, o, len});
    endtask
    task automatic instr(input int n, input logic [7:0] b1, b2, b3);
        awc_fetch_model_i.push(1'b1, b1);
        if (n > 1) awc_fetch_model_i.push(1'b0, b2);
        if (n > 2) awc_fetch_model_i.push(1'b0, b3);
    endtask
    task automatic end_test(input string name);
        for (int i = 0; i < 400 && (awc_fetch_model_i.pend.size() > 0 || fetch_valid || notes.size() > 0); i++)
            @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        compare(25'(notes.size()), 25'h0);
        notes.delete();
        $display("test %s done: checks %0d failures %0d", name, checks, failures);
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Result monitor
    // ==========================================================
    // Every pulse consumes the oldest note; a pulse with nothing noted is itself a fault.
    always @(posedge clk_sys) begin
        if (arst_n && (dec_valid === 1'b1 || dec_undefined === 1'b1 || dec_other === 1'b1)) begin
            if (notes.size() == 0) begin
                compare(25'h1FFFFFF, 25'h0);
            end else begin
                compare({dec_valid, dec_undefined, dec_other, dec_form, dest_register_field, source_register_field,
                    dec_operand, dec_length} & notes[0][49:25], notes[0][24:0]);
                compare({24'h0, add_with_carry_op}, {24'h0, notes[0][24]});
                void'(notes.pop_front());
            end
            compare({24'h0, fetch_ready}, 25'h1);
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // A hang is cut short well past the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict();
    end
    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        arst_n = 1'b0;
        void'($urandom(94589));
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // Every operand-form code twice; both passes are queued at once, so all of them run with 40 percent random stalls.
        for (int p = 0; p < 2; p++) begin
            awc_fetch_model_i.stall_pct = p * 40;
            for (int n = 0; n < 7; n++) begin
                r8 = $urandom;
                v8 = $urandom;
                instr(3, AWC_OP_REG_FORMS, {r8[3:0], 4'(n)}, v8);
                note(3'b100, form_of[n], r8[3:0], 3'h0, v8, 3'h3, 25'h1FFFFFF);
            end
        end
        end_test("forms");
        // Register pairs, short and prefixed, with bit 3 set as well.
        for (int n = 0; n < 6; n++) begin
            r8 = $urandom;
            r8[3] = (n > 3);
            if (n[0]) instr(3, AWC_OP_PREFIX, AWC_OP_RR_LONG, r8);
            else instr(2, AWC_OP_RR_SHORT, r8, 8'h00);
            note({1'b1, r8[3], 1'b0}, AWC_FORM_R_R, r8[7:4], r8[2:0], 8'h00, n[0] ? 3'h3 : 3'h2, 25'h1FFF807);
        end
        end_test("pairs");
        // Undefined codes; the trailing byte is ignored until the next first byte.
        for (int n = 7; n < 16; n++) begin
            instr(3, AWC_OP_REG_FORMS, {4'hA, 4'(n)}, 8'h89);
            note(3'b010, 4'h0, 4'h0, 3'h0, 8'h00, 3'h0, 25'h1C00000);
        end
        end_test("undefined");
        // A foreign first byte and a prefix not followed by the pair opcode.
        instr(2, 8'hA9, 8'h79, 8'h00);
        note(3'b001, 4'h0, 4'h0, 3'h0, 8'h00, 3'h0, 25'h1C00000);
        instr(3, AWC_OP_PREFIX, 8'h07, 8'h29);
        note(3'b001, 4'h0, 4'h0, 3'h0, 8'h00, 3'h0, 25'h1C00000);
        end_test("other");
        // Reset in mid-instruction must drop the half-decoded bytes; a stray operand byte after it proves the drop.
        awc_fetch_model_i.stall_pct = 0;
        instr(2, AWC_OP_REG_FORMS, 8'h53, 8'h00);
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        awc_fetch_model_i.push(1'b0, 8'hC4);
        instr(2, AWC_OP_RR_SHORT, 8'h65, 8'h00);
        note(3'b100, AWC_FORM_R_R, 4'h6, 3'h5, 8'h00, 3'h2, 25'h1FFF807);
        end_test("reset");
        give_verdict();
    end
endmodule
